//--- core/pmr_defs.svh
// Register offsets, field positions, reset values and timing counts of the management bank
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define PMR_ADDR_CONTROL 5'h00
`define PMR_ADDR_STATUS 5'h01
`define PMR_ADDR_EXT_STATUS 5'h0F
`define PMR_ADDR_LOOPBACK 5'h13
`define PMR_ADDR_MGMT_CTL 5'h15

// ****************************************************************
// Basic control fields
// ****************************************************************
`define PMR_CTL_RESET 15
`define PMR_CTL_LOOPBACK 14
`define PMR_CTL_SPEED_LSB 13
`define PMR_CTL_AN_ENABLE 12
`define PMR_CTL_POWERDOWN 11
`define PMR_CTL_ISOLATE 10
`define PMR_CTL_AN_RESTART 9
`define PMR_CTL_DUPLEX 8
`define PMR_CTL_COLL_TEST 7
`define PMR_CTL_SPEED_MSB 6

// ****************************************************************
// Basic status fields
// ****************************************************************
`define PMR_ST_100_T4 15
`define PMR_ST_100X_FD 14
`define PMR_ST_100X_HD 13
`define PMR_ST_10_FD 12
`define PMR_ST_10_HD 11
`define PMR_ST_100_T2_FD 10
`define PMR_ST_100_T2_HD 9
`define PMR_ST_EXT_STATUS 8
`define PMR_ST_PREAMBLE_SUPP 6
`define PMR_ST_AN_COMPLETE 5
`define PMR_ST_REMOTE_FAULT 4
`define PMR_ST_AN_ABILITY 3
`define PMR_ST_LINK 2
`define PMR_ST_JABBER 1
`define PMR_ST_EXT_CAP 0

// Loopback control: bit 0 selects the kind of loopback that the master enable turns on
`define PMR_LB_ANALOG 0

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define PMR_ZERO_WORD 16'h0000
`define PMR_CLK_PERIOD_NS 100
`define PMR_SOFT_RESET_NS 10000
`define PMR_SOFT_RESET_CYCLES ((`PMR_SOFT_RESET_NS + `PMR_CLK_PERIOD_NS - 1) / `PMR_CLK_PERIOD_NS)

`endif

//--- core/pmr_pkg.sv
// Types shared by the management register bank
package pmr_pkg;

    // Soft reset sequencer states
    typedef enum logic [0:0] {
        PMR_RST_IDLE = 1'b0,
        PMR_RST_BUSY = 1'b1
    } pmr_rst_state_type;

    // Speed encoding, high bit first
    typedef enum logic [1:0] {
        PMR_SPEED_10 = 2'b00,
        PMR_SPEED_100 = 2'b01,
        PMR_SPEED_1000 = 2'b10,
        PMR_SPEED_RSVD = 2'b11
    } pmr_speed_type;

endpackage

//--- core/pmr_word_store.sv
// Word storage for the management registers kept outside the basic pair
`timescale 1ns/1ps

module pmr_word_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    // Refuse shapes the address cannot cover
    if (DEPTH < 1 || DEPTH > (1 << AW) || WIDTH < 1) begin : g_bad_shape
        $error("pmr_word_store: unsupported WIDTH/DEPTH/AW");
    end

    logic [WIDTH-1:0] word_reg [DEPTH];

    // One writable word per entry, cleared by reset so reads never show unknowns
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_word
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    word_reg[gi] <= '0;
                end else if (wr_en && wr_addr == AW'(gi)) begin
                    word_reg[gi] <= wr_data;
                end
            end
        end
    endgenerate

    // Registered read port
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_data <= '0;
        end else begin
            rd_data <= word_reg[rd_addr];
        end
    end

endmodule

//--- core/pmr_mgmt_regs.sv
// Basic control and status management registers with address decode and soft reset
//
// Notes on behaviour
// - Writing control bit 15 starts soft reset; reads one, self-clears when done.
// - Control bit 14 enables loopback; loopback register 19 picks digital or analog.
// - Forced speed {bit6,bit13}: 10 gigabit, 01 hundred, 00 ten, 11 reserved.
// - Forced speed bits steer the link only while autonegotiation is off.
// - Reset loads forced speed bits from the speed strap pins.
// - Control bit 8 full duplex; only when autonegotiation off; loaded from duplex strap.
// - Control bit 12 enables autonegotiation, defaults one; off means manual config.
// - Control bit 10 isolates the device from the MAC-side interface.
// - Writing control bit 9 restarts autonegotiation; clears when restart completes.
// - Control bit 7 enables the collision test.
// - Read-only fields, control bits 5:0 included, ignore writes; 5:0 read zero.
// - Status bits 14:11 loaded at reset from speed and duplex straps.
// - Status bits 15, 10 and 9 always read zero.
// - Status bits 8, 3 and 0 always read one.
// - Status bit 6 reads one; preamble-less management frames accepted.
// - Status bit 5 reads zero until autonegotiation completes.
// - Status bit 4 latches high on remote fault; cleared by status read or reset.
// - Status bit 2 shows link; latches low on failure until status is read.
// - Status bit 1 latches high on jabber.
// - Thirty-two addresses decoded; 11-14, 16-17, 20, 29-31 reserved.
// - Extended register set is every register except 0, 1 and 15.
`timescale 1ns/1ps
`include "pmr_defs.svh"

module pmr_mgmt_regs #(
    parameter int SOFT_RESET_CYCLES = `PMR_SOFT_RESET_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic strap_speed_10,
    input wire logic strap_speed_100,
    input wire logic strap_speed_1000,
    input wire logic strap_duplex,
    input wire logic [4:0] mgmt_addr,
    input wire logic mgmt_wr_en,
    input wire logic [15:0] mgmt_wr_data,
    input wire logic mgmt_rd_en,
    output logic [15:0] mgmt_rd_data,
    output logic mgmt_rd_valid,
    input wire logic an_complete,
    input wire logic an_restart_done,
    input wire logic [1:0] an_speed,
    input wire logic an_full_duplex,
    input wire logic link_up,
    input wire logic remote_fault,
    input wire logic jabber,
    output logic soft_reset_active,
    output logic loopback_en,
    output logic loopback_analog,
    output logic an_enable,
    output logic [1:0] link_speed,
    output logic link_full_duplex,
    output logic isolate_en,
    output logic powerdown_en,
    output logic an_restart_req,
    output logic collision_test_en
);

    // Refuse a zero-length sequence or one the 16-bit counter cannot reach
    if (SOFT_RESET_CYCLES < 1 || SOFT_RESET_CYCLES > 65535) begin : g_bad_len
        $error("pmr_mgmt_regs: SOFT_RESET_CYCLES out of range");
    end

    // ****************************************************************
    // Decode
    // ****************************************************************

    // Reserved holes of the 32-entry map
    function automatic logic addr_reserved(input logic [4:0] a);
        addr_reserved = (a >= 5'h0B && a <= 5'h0E) || a == 5'h10 || a == 5'h11
            || a == 5'h14 || a >= 5'h1D;
    endfunction

    pmr_pkg::pmr_rst_state_type rst_state_reg;
    logic [15:0] rst_count_reg;
    logic [15:0] ctl_reg;
    logic [3:0] ability_reg;
    logic lb_analog_reg;
    logic fault_latch_reg;
    logic jabber_latch_reg;
    logic link_latch_reg;
    logic [15:0] hold_reg;
    logic [4:0] rd_addr_reg;
    logic [4:0] rd_addr2_reg;
    logic rd_pend_reg;
    logic rd_valid_reg;
    logic [15:0] rd_data_reg;
    logic [15:0] mem_q;
    logic [15:0] status_word;
    logic [15:0] ctl_default;
    logic wr_ok;
    logic wr_ctl;
    logic wr_lb;
    logic wr_mem;
    logic rd_status;
    logic seq_done;
    logic rst_busy;

    assign rst_busy = rst_state_reg == pmr_pkg::PMR_RST_BUSY;
    // Writes are ignored while the soft reset runs; its end reloads everything anyway
    assign wr_ok = mgmt_wr_en && !rst_busy;
    assign wr_ctl = wr_ok && mgmt_addr == `PMR_ADDR_CONTROL;
    assign wr_lb = wr_ok && mgmt_addr == `PMR_ADDR_LOOPBACK;
    // Status is read-only; reserved holes drop the write
    assign wr_mem = wr_ok && !addr_reserved(mgmt_addr) && mgmt_addr != `PMR_ADDR_STATUS
        && mgmt_addr != `PMR_ADDR_CONTROL && mgmt_addr != `PMR_ADDR_LOOPBACK;
    assign rd_status = mgmt_rd_en && mgmt_addr == `PMR_ADDR_STATUS;
    assign seq_done = rst_busy && rst_count_reg == 16'(SOFT_RESET_CYCLES - 1);

    // ****************************************************************
    // Strap-derived defaults
    // ****************************************************************

    // Control default with speed and duplex taken from the pins
    always_comb begin
        ctl_default = `PMR_ZERO_WORD;
        ctl_default[`PMR_CTL_AN_ENABLE] = 1'b1;
        ctl_default[`PMR_CTL_SPEED_MSB] = strap_speed_1000;
        ctl_default[`PMR_CTL_SPEED_LSB] = strap_speed_100 && !strap_speed_1000;
        ctl_default[`PMR_CTL_DUPLEX] = strap_duplex;
    end

    // Ability bits caught from the straps at each reset
    always_ff @(posedge ref_clk) begin
        if (reset || seq_done) begin
            ability_reg <= {strap_speed_100 && strap_duplex, strap_speed_100,
                            strap_speed_10 && strap_duplex, strap_speed_10};
        end
    end

    // ****************************************************************
    // Soft reset sequencer
    // ****************************************************************

    // Counts the sequence length, then returns to idle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rst_state_reg <= pmr_pkg::PMR_RST_IDLE;
            rst_count_reg <= 16'h0000;
        end else begin
            case (rst_state_reg)
                pmr_pkg::PMR_RST_IDLE: begin
                    rst_count_reg <= 16'h0000;
                    if (wr_ctl && mgmt_wr_data[`PMR_CTL_RESET]) begin
                        rst_state_reg <= pmr_pkg::PMR_RST_BUSY;
                    end
                end
                pmr_pkg::PMR_RST_BUSY: begin
                    if (seq_done) begin
                        rst_state_reg <= pmr_pkg::PMR_RST_IDLE;
                    end else begin
                        rst_count_reg <= rst_count_reg + 16'h0001;
                    end
                end
                default: begin
                    rst_state_reg <= pmr_pkg::PMR_RST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************

    // Writable fields; bit 15 and 9 self-clear, 5:0 never stored
    always_ff @(posedge ref_clk) begin
        if (reset || seq_done) begin
            ctl_reg <= ctl_default;
        end else begin
            if (wr_ctl) begin
                ctl_reg[15:6] <= mgmt_wr_data[15:6];
                ctl_reg[5:0] <= 6'h00;
            end
            if (rst_busy) begin
                ctl_reg[`PMR_CTL_RESET] <= 1'b1;
            end
            // A restart request written in the completing cycle is kept
            if (an_restart_done && !(wr_ctl && mgmt_wr_data[`PMR_CTL_AN_RESTART])) begin
                ctl_reg[`PMR_CTL_AN_RESTART] <= 1'b0;
            end
        end
    end

    // Loopback kind select
    always_ff @(posedge ref_clk) begin
        if (reset || seq_done) begin
            lb_analog_reg <= 1'b0;
        end else if (wr_lb) begin
            lb_analog_reg <= mgmt_wr_data[`PMR_LB_ANALOG];
        end
    end

    // ****************************************************************
    // Latching status bits
    // ****************************************************************

    // Remote fault latches high; a new fault beats the read clear
    always_ff @(posedge ref_clk) begin
        if (reset || seq_done) begin
            fault_latch_reg <= 1'b0;
        end else if (remote_fault) begin
            fault_latch_reg <= 1'b1;
        end else if (rd_status) begin
            fault_latch_reg <= 1'b0;
        end
    end

    // Jabber latches high, clears on read only once the condition is gone
    always_ff @(posedge ref_clk) begin
        if (reset || seq_done) begin
            jabber_latch_reg <= 1'b0;
        end else if (jabber) begin
            jabber_latch_reg <= 1'b1;
        end else if (rd_status) begin
            jabber_latch_reg <= 1'b0;
        end
    end

    // Link latches low; a status read re-arms it from the live link
    always_ff @(posedge ref_clk) begin
        if (reset || seq_done) begin
            link_latch_reg <= 1'b0;
        end else if (!link_up) begin
            link_latch_reg <= 1'b0;
        end else if (rd_status) begin
            link_latch_reg <= 1'b1;
        end
    end

    // Status word as software sees it
    always_comb begin
        status_word = `PMR_ZERO_WORD;
        status_word[`PMR_ST_100_T4] = 1'b0;
        status_word[`PMR_ST_100_T2_FD] = 1'b0;
        status_word[`PMR_ST_100_T2_HD] = 1'b0;
        status_word[14:11] = ability_reg;
        status_word[`PMR_ST_EXT_STATUS] = 1'b1;
        status_word[`PMR_ST_PREAMBLE_SUPP] = 1'b1;
        status_word[`PMR_ST_AN_COMPLETE] = an_complete;
        status_word[`PMR_ST_REMOTE_FAULT] = fault_latch_reg;
        status_word[`PMR_ST_AN_ABILITY] = 1'b1;
        status_word[`PMR_ST_LINK] = link_latch_reg;
        status_word[`PMR_ST_JABBER] = jabber_latch_reg;
        status_word[`PMR_ST_EXT_CAP] = 1'b1;
    end

    // ****************************************************************
    // Read path
    // ****************************************************************

    // Other registers live in plain storage, cleared by either kind of reset
    pmr_word_store #(
        .WIDTH(16),
        .DEPTH(32),
        .AW(5)
    ) u_store (
        .ref_clk(ref_clk),
        .reset(reset || seq_done),
        .wr_en(wr_mem),
        .wr_addr(mgmt_addr),
        .wr_data(mgmt_wr_data),
        .rd_addr(mgmt_addr),
        .rd_data(mem_q)
    );

    // Stage one: capture local value at the taking edge, before latches clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hold_reg <= `PMR_ZERO_WORD;
            rd_addr_reg <= 5'h00;
            rd_pend_reg <= 1'b0;
        end else begin
            rd_pend_reg <= mgmt_rd_en;
            rd_addr_reg <= mgmt_addr;
            if (addr_reserved(mgmt_addr)) begin
                hold_reg <= `PMR_ZERO_WORD;
            end else if (mgmt_addr == `PMR_ADDR_CONTROL) begin
                hold_reg <= ctl_reg;
            end else if (mgmt_addr == `PMR_ADDR_STATUS) begin
                hold_reg <= status_word;
            end else begin
                hold_reg <= {15'h0000, lb_analog_reg};
            end
        end
    end

    // Stage two: pick storage or local word; two cycles trade latency for flop outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_data_reg <= `PMR_ZERO_WORD;
            rd_valid_reg <= 1'b0;
            rd_addr2_reg <= 5'h00;
        end else begin
            rd_valid_reg <= rd_pend_reg;
            rd_addr2_reg <= rd_addr_reg;
            if (rd_pend_reg) begin
                if (addr_reserved(rd_addr_reg) || rd_addr_reg == `PMR_ADDR_CONTROL
                    || rd_addr_reg == `PMR_ADDR_STATUS || rd_addr_reg == `PMR_ADDR_LOOPBACK) begin
                    rd_data_reg <= hold_reg;
                end else begin
                    rd_data_reg <= mem_q;
                end
            end
        end
    end

    assign mgmt_rd_data = rd_data_reg;
    assign mgmt_rd_valid = rd_valid_reg;

    // ****************************************************************
    // Outputs to the datapath
    // ****************************************************************

    // Forced settings only count with autonegotiation off
    assign an_enable = ctl_reg[`PMR_CTL_AN_ENABLE];
    assign link_speed = an_enable ? an_speed
        : {ctl_reg[`PMR_CTL_SPEED_MSB], ctl_reg[`PMR_CTL_SPEED_LSB]};
    assign link_full_duplex = an_enable ? an_full_duplex : ctl_reg[`PMR_CTL_DUPLEX];
    assign soft_reset_active = rst_busy;
    assign loopback_en = ctl_reg[`PMR_CTL_LOOPBACK];
    assign loopback_analog = lb_analog_reg;
    assign isolate_en = ctl_reg[`PMR_CTL_ISOLATE];
    assign powerdown_en = ctl_reg[`PMR_CTL_POWERDOWN];
    assign an_restart_req = ctl_reg[`PMR_CTL_AN_RESTART];
    assign collision_test_en = ctl_reg[`PMR_CTL_COLL_TEST];

    // ****************************************************************
    // Checks
    // ****************************************************************

    // Busy length as seen from outside, counted apart from the sequencer's own counter
    logic [15:0] busy_len_reg;
    always_ff @(posedge ref_clk) begin
        if (reset || !soft_reset_active) begin
            busy_len_reg <= 16'h0000;
        end else begin
            busy_len_reg <= busy_len_reg + 16'h0001;
        end
    end

    chk_reset_holds: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(soft_reset_active) |-> busy_len_reg == 16'(SOFT_RESET_CYCLES))
        else $error("soft reset length wrong");

    chk_reset_ends: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(soft_reset_active) |-> ##[1:200] !soft_reset_active ##1 !ctl_reg[15])
        else $error("soft reset bit did not self-clear");

    chk_forced_speed: assert property (@(posedge ref_clk) disable iff (reset)
        !an_enable |-> link_speed == {ctl_reg[6], ctl_reg[13]} && link_full_duplex == ctl_reg[8])
        else $error("forced speed or duplex not applied");

    chk_an_speed: assert property (@(posedge ref_clk) disable iff (reset)
        an_enable |-> link_speed == an_speed)
        else $error("forced speed leaked under autonegotiation");

    chk_restart_clear: assert property (@(posedge ref_clk) disable iff (reset)
        (an_restart_req && an_restart_done && !wr_ctl && !rst_busy) |=> !an_restart_req)
        else $error("restart bit did not self-clear");

    chk_ctl_low_zero: assert property (@(posedge ref_clk) disable iff (reset)
        mgmt_rd_valid && rd_addr2_reg == 5'h00 |-> mgmt_rd_data[5:0] == 6'h00)
        else $error("control low bits not zero");

    chk_status_fixed: assert property (@(posedge ref_clk) disable iff (reset)
        mgmt_rd_valid && rd_addr2_reg == 5'h01 |-> mgmt_rd_data[15] == 1'b0
        && mgmt_rd_data[10:9] == 2'b00 && mgmt_rd_data[8] && mgmt_rd_data[6]
        && mgmt_rd_data[3] && mgmt_rd_data[0])
        else $error("fixed status bits wrong");

    chk_fault_latch: assert property (@(posedge ref_clk) disable iff (reset || rst_busy)
        remote_fault |=> fault_latch_reg ##1 (fault_latch_reg || $past(rd_status)))
        else $error("remote fault not latched");

    chk_link_low: assert property (@(posedge ref_clk) disable iff (reset)
        !link_up && !seq_done |=> !link_latch_reg)
        else $error("link failure not latched low");

    chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (reset)
        mgmt_rd_valid && addr_reserved(rd_addr2_reg) |-> mgmt_rd_data == 16'h0000)
        else $error("reserved address read nonzero");

endmodule

//--- test/pmr_sta_model.sv
// Station management controller model driving the register port
`timescale 1ns/1ps
module pmr_sta_model (
    input wire logic ref_clk,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    output logic [4:0] addr,
    output logic wr_en,
    output logic [15:0] wr_data,
    output logic rd_en
);
    // Idle port from time zero
    initial begin
        addr = 5'h00;
        wr_en = 1'b0;
        wr_data = 16'h0000;
        rd_en = 1'b0;
    end
    // One strobe, then data flips so a stale word is never mistaken for fresh
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        wr_data <= ~d;
    endtask
    // Valid stands one cycle from the first edge after taking; the word is taken
    // at the edge that samples it high, before that edge retires it
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        repeat (2) @(posedge ref_clk);
        d = (rd_valid === 1'b1) ? rd_data : 16'hxxxx;
    endtask
endmodule

//--- test/pmr_mgmt_regs_tb_top.sv
// Self-checking bench for the management register bank
`timescale 1ns/1ps
module pmr_mgmt_regs_tb_top;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic s10 = 1'b1, s100 = 1'b1, s1000 = 1'b0, sdup = 1'b1;
    logic an_cmp = 1'b0, an_done = 1'b0, an_fd = 1'b1, lnk = 1'b1, rflt = 1'b0, jab = 1'b0;
    logic [1:0] an_spd = 2'b01;
    logic [1:0] spd;
    logic [4:0] addr;
    logic wr_en, rd_en, rd_valid, sr_act, lb_en, lb_an, an_en, fd, iso, pd, rst_req, col;
    logic [15:0] wdata, rdata, v;
    int n_mismatch = 0;
    int cmp_count = 0;

    // Clock at 10 MHz
    always #50 ref_clk = ~ref_clk;

    pmr_sta_model sta_u (.ref_clk(ref_clk), .rd_data(rdata), .rd_valid(rd_valid),
        .addr(addr), .wr_en(wr_en), .wr_data(wdata), .rd_en(rd_en));

    // Soft reset shortened so the busy window fits a short run
    pmr_mgmt_regs #(.SOFT_RESET_CYCLES(4)) dut_u (.ref_clk(ref_clk), .reset(reset),
        .strap_speed_10(s10), .strap_speed_100(s100), .strap_speed_1000(s1000),
        .strap_duplex(sdup), .mgmt_addr(addr), .mgmt_wr_en(wr_en), .mgmt_wr_data(wdata),
        .mgmt_rd_en(rd_en), .mgmt_rd_data(rdata), .mgmt_rd_valid(rd_valid),
        .an_complete(an_cmp), .an_restart_done(an_done), .an_speed(an_spd),
        .an_full_duplex(an_fd), .link_up(lnk), .remote_fault(rflt), .jabber(jab),
        .soft_reset_active(sr_act), .loopback_en(lb_en), .loopback_analog(lb_an),
        .an_enable(an_en), .link_speed(spd), .link_full_duplex(fd), .isolate_en(iso),
        .powerdown_en(pd), .an_restart_req(rst_req), .collision_test_en(col));

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Strap defaults, then live status bit and link latch set by a read
    task automatic t_reset();
        sta_u.rd(5'h00, v);
        chk(v, 16'h3100);
        sta_u.rd(5'h01, v);
        chk(v, 16'h7949);
        @(posedge ref_clk) an_cmp <= 1'b1;
        sta_u.rd(5'h01, v);
        chk(v, 16'h796D);
    endtask

    // Manual mode drives outputs; autoneg mode overrides the forced bits
    task automatic t_ctl();
        sta_u.wr(5'h00, 16'h44FF);
        sta_u.rd(5'h00, v);
        chk(v, 16'h44C0);
        chk({11'h0, lb_en, iso, col, an_en, fd}, 16'h001C);
        chk({14'h0, spd}, 16'h0002);
        sta_u.wr(5'h00, 16'h1000);
        #1;
        chk({13'h0, spd, fd}, 16'h0003);
    endtask

    // Latched status bits hold a brief event until read
    task automatic t_latch();
        @(posedge ref_clk);
        rflt <= 1'b1;
        jab <= 1'b1;
        lnk <= 1'b0;
        @(posedge ref_clk);
        rflt <= 1'b0;
        jab <= 1'b0;
        lnk <= 1'b1;
        sta_u.rd(5'h01, v);
        chk(v & 16'h0016, 16'h0012);
        sta_u.rd(5'h01, v);
        chk(v & 16'h0016, 16'h0004);
    endtask

    // Restart request stands until the autoneg side reports done
    task automatic t_restart();
        sta_u.wr(5'h00, 16'h1200);
        #1;
        chk({15'h0, rst_req}, 16'h0001);
        @(posedge ref_clk) an_done <= 1'b1;
        @(posedge ref_clk) an_done <= 1'b0;
        sta_u.rd(5'h00, v);
        chk(v, 16'h1000);
    endtask

    // Reserved holes, read-only status, storage and loopback kind
    task automatic t_map();
        logic [4:0] rsv [7];
        rsv = '{5'd11, 5'd14, 5'd16, 5'd17, 5'd20, 5'd29, 5'd31};
        foreach (rsv[i]) begin
            sta_u.wr(rsv[i], 16'hFFFF);
            sta_u.rd(rsv[i], v);
            chk(v, 16'h0000);
        end
        sta_u.wr(5'h01, 16'h0000);
        sta_u.rd(5'h01, v);
        chk(v & 16'hFF49, 16'h7949);
        sta_u.wr(5'h02, 16'h5A5A);
        sta_u.rd(5'h02, v);
        chk(v, 16'h5A5A);
        sta_u.wr(5'h13, 16'h0001);
        #1;
        chk({15'h0, lb_an}, 16'h0001);
    endtask

    // Soft reset reads busy, then reloads with straps sampled again
    task automatic t_soft();
        int n;
        sta_u.wr(5'h00, 16'h4800);
        #1;
        chk({15'h0, pd}, 16'h0001);
        @(posedge ref_clk) s1000 <= 1'b1;
        sta_u.wr(5'h00, 16'h8000);
        #1;
        chk({15'h0, sr_act}, 16'h0001);
        sta_u.rd(5'h00, v);
        chk({15'h0, v[15]}, 16'h0001);
        n = 0;
        while (sr_act !== 1'b0 && n < 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        sta_u.rd(5'h00, v);
        chk(v, 16'h1140);
        chk({15'h0, pd}, 16'h0000);
    endtask

    // Watchdog sized well above the whole sequence
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_mismatch++;
        final_report();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_ctl();
        t_latch();
        t_restart();
        t_map();
        t_soft();
        final_report();
    end
endmodule
